// *** pgca_pkg.sv ***
// constants and carrier types for the programmable counter array
// assumes a single 200 MHz clock domain shared by all users of this package
package pgca_pkg;

  // structure
  localparam int NUM_MODULES = 5;
  localparam int CNT_W = 16;
  localparam int WDOG_MODULE = 4;

  // clock rate, kept for deriving any timed figure
  localparam int MCLK_MHZ = 200;

  // count source select encodings
  localparam logic [1:0] SRC_DIV6 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_TMR0 = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // prescaler terminal counts
  localparam logic [2:0] DIV6_LAST = 3'h5;
  localparam logic [2:0] DIV6_RESET = 3'h0;

  // reset values and limits
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] LOW_MAX = 8'hFF;

  // counter mode and control bits, written by software
  typedef struct packed {
    logic haltInIdle;        // stop counting while the cpu idles
    logic watchdogEnable;    // module 4 acts as watchdog
    logic [1:0] countSource; // count pulse select
    logic overflowIrqEnable; // overflow flag may request interrupt
    logic counterRun;        // counter runs while set
  } pgca_counter_cfg_type;

  // per-module mode bits, written by software
  typedef struct packed {
    logic comparatorEnable;      // enables compare function
    logic riseEdgeCaptureEnable; // capture on rising pin edge
    logic fallEdgeCaptureEnable; // capture on falling pin edge
    logic compareHitFlagEnable;  // match sets event flag
    logic outputFlipEnable;      // match toggles pin
    logic pwmEnable;             // pwm mode
    logic moduleIrqEnable;       // event flag may request interrupt
  } pgca_module_mode_type;

  // software write strobes for one module's compare bytes
  typedef struct packed {
    logic wrLow;      // write compare low byte
    logic wrHigh;     // write compare high byte
    logic [7:0] data; // byte to write
  } pgca_compare_write_type;

endpackage

// *** pgca_top.sv ***
// programmable counter array: shared 16-bit time base and five capture/compare modules
// assumes control bits come from same-clock software logic; pins are asynchronous
//
// What this block does
// R01 - counter advances from software-chosen source: clk/6, clk/2, timer0 overflow, pin
// R02 - select 00 is clk/6, 01 clk/2, 10 timer0, 11 pin at most clk/4
// R03 - one 16-bit counter is the time base for all five modules
// R04 - with halt-in-idle set, counting stops while cpu is idle
// R05 - counter counts only while the run bit is set
// R06 - overflow sets sticky flag, requests interrupt if enabled; only software clears
// R07 - each module has an event flag set on capture or on a match with hit-flag enable set, software clears
// R08 - five module sources and overflow share one interrupt request
// R09 - module event flag interrupts only when its interrupt enable is set
// R10 - fall and rise enables pick capture edge; both give either edge
// R11 - valid enabled pin edge copies counter into compare bytes, sets event flag
// R12 - comparator enable makes the module compare counter to its compare bytes
// R13 - timer mode: comparator and hit-flag enables set, match sets event flag
// R14 - output mode: flip, hit-flag and comparator enables set, match inverts pin
// R15 - pwm pin low while counter low byte below compare low, else high
// R16 - pwm: on low byte wrap ff to 00, compare low reloads from high
// R17 - pwm active only with both pwm and comparator enables set
// R18 - only module 4 does watchdog, only while watchdog enable is set
// R19 - watchdog match raises internal reset, never drives the reset pin
// R20 - software should refresh module 4 compare value to avoid watchdog reset
// R21 - pins not claimed by the array keep plain general purpose behaviour
// R22 - counter increments per count pulse, wraps ffff to 0000, wrap is overflow
module pgca_top (
  input wire logic mclk, // 200 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic idleMode, // cpu is in idle, same clock
  input wire logic tmr0Overflow, // timer 0 overflow pulse, same clock
  input wire logic extCountInput, // external count pin, async
  input wire pgca_pkg::pgca_counter_cfg_type counterCfg, // counter mode and run bits
  input wire pgca_pkg::pgca_module_mode_type moduleMode [pgca_pkg::NUM_MODULES], // modes
  input wire pgca_pkg::pgca_compare_write_type cmpWrite [pgca_pkg::NUM_MODULES], // writes
  input wire logic overflowFlagClr, // software clears overflow flag
  input wire logic [pgca_pkg::NUM_MODULES-1:0] eventFlagClr, // software clears event flags
  input wire logic [pgca_pkg::NUM_MODULES-1:0] moduleIoPinIn, // module pin levels, async
  input wire logic [pgca_pkg::NUM_MODULES-1:0] gpioOut, // port latch value for free pins
  input wire logic [pgca_pkg::NUM_MODULES-1:0] gpioOe, // port drive enable for free pins
  output logic [pgca_pkg::CNT_W-1:0] countValue, // counter high and low bytes
  output logic [7:0] moduleCompareLow [pgca_pkg::NUM_MODULES], // compare low bytes
  output logic [7:0] moduleCompareHigh [pgca_pkg::NUM_MODULES], // compare high bytes
  output logic counterOverflowFlag, // sticky overflow flag
  output logic [pgca_pkg::NUM_MODULES-1:0] moduleEventFlag, // sticky event flags
  output logic irqRequest, // shared interrupt request, level
  output logic watchdogReset, // internal reset pulse
  output logic [pgca_pkg::NUM_MODULES-1:0] moduleIoPinOut, // pin output level
  output logic [pgca_pkg::NUM_MODULES-1:0] moduleIoPinOe // pin drive enable
);

  localparam int NM = pgca_pkg::NUM_MODULES;

  logic rstMeta_q;
  logic rstnSync_q;
  logic extMeta_q;
  logic extSync_q;
  logic extPrev_q;
  logic [2:0] div6Cnt_q;
  logic div2Phase_q;
  logic srcPulse;
  logic countOn;
  logic tick;
  logic [15:0] cnt_q;
  logic [15:0] cntNext;
  logic overflowHit;
  logic ovfFlag_q;
  logic irq_q;
  logic wdogHit;
  logic wdogReset_q;
  logic [NM-1:0] pinMeta_q;
  logic [NM-1:0] pinSync_q;
  logic [NM-1:0] pinPrev_q;
  logic [NM-1:0] captureHit;
  logic [NM-1:0] matchHit;
  logic [NM-1:0] pwmOn;
  logic [NM-1:0] hsoOn;
  logic [NM-1:0] eventSet;
  logic [NM-1:0] irqEnVec;
  logic [NM-1:0] eventFlag_q;
  logic [NM-1:0] ioOut_q;
  logic [NM-1:0] ioOe_q;
  logic [7:0] cmpLow_q [NM];
  logic [7:0] cmpHigh_q [NM];

  // every property below runs on the one clock and sleeps while reset is held
  default clocking cb_main @(posedge mclk); endclocking
  default disable iff (!rstnSync_q);

  // full 16-bit compare match, shared by every module and the watchdog
  function automatic logic hitsValue(input logic [15:0] a, input logic [7:0] hi,
                                     input logic [7:0] lo);
    hitsValue = (a == {hi, lo});
  endfunction

  // reset release through two flops; assertion is immediate, release is clocked
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstnSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstnSync_q <= rstMeta_q;
    end
  end

  // external count pin: two-flop sync, then a third flop for edge detection
  always_ff @(posedge mclk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      extMeta_q <= 1'b0;
      extSync_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      extMeta_q <= extCountInput;
      extSync_q <= extMeta_q;
      extPrev_q <= extSync_q;
    end
  end

  // free-running prescalers; left running when the counter stops so no state is lost
  always_ff @(posedge mclk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      div6Cnt_q <= pgca_pkg::DIV6_RESET;
      div2Phase_q <= 1'b0;
    end else begin
      div6Cnt_q <= (div6Cnt_q == pgca_pkg::DIV6_LAST) ? pgca_pkg::DIV6_RESET
                                                      : 3'(div6Cnt_q + 3'h1);
      div2Phase_q <= ~div2Phase_q;
    end
  end

  // count pulse select; the pin source relies on edges no faster than clk/4
  always_comb begin
    case (counterCfg.countSource) // R01
      pgca_pkg::SRC_DIV6: srcPulse = (div6Cnt_q == pgca_pkg::DIV6_LAST); // R02
      pgca_pkg::SRC_DIV2: srcPulse = div2Phase_q; // R02
      pgca_pkg::SRC_TMR0: srcPulse = tmr0Overflow; // R02
      default: srcPulse = extSync_q & ~extPrev_q; // R02
    endcase
  end

  // run gating and idle hold
  assign countOn = counterCfg.counterRun && !(counterCfg.haltInIdle && idleMode); // R04 R05
  assign tick = countOn && srcPulse;
  assign cntNext = cnt_q + pgca_pkg::CNT_ONE; // R22
  assign overflowHit = tick && (cnt_q == pgca_pkg::CNT_MAX); // R22

  // the single shared time base
  always_ff @(posedge mclk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      cnt_q <= pgca_pkg::CNT_RESET;
    end else if (tick) begin
      cnt_q <= cntNext; // R03 R22
    end
  end

  // overflow flag: set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      ovfFlag_q <= 1'b0;
    end else if (overflowHit) begin
      ovfFlag_q <= 1'b1; // R06
    end else if (overflowFlagClr) begin
      ovfFlag_q <= 1'b0; // R06
    end
  end

  // per-module capture, compare, pwm and pin logic
  genvar i;
  generate
    for (i = 0; i < NM; i++) begin : g_mod
      // pin sync; only the second flop and later feed edge logic
      always_ff @(posedge mclk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
          pinMeta_q[i] <= 1'b0;
          pinSync_q[i] <= 1'b0;
          pinPrev_q[i] <= 1'b0;
        end else begin
          pinMeta_q[i] <= moduleIoPinIn[i];
          pinSync_q[i] <= pinMeta_q[i];
          pinPrev_q[i] <= pinSync_q[i];
        end
      end

      assign captureHit[i] =
          (moduleMode[i].riseEdgeCaptureEnable & pinSync_q[i] & ~pinPrev_q[i]) | // R10
          (moduleMode[i].fallEdgeCaptureEnable & ~pinSync_q[i] & pinPrev_q[i]); // R10
      // match is judged on the value the counter is stepping to, so once per step
      assign matchHit[i] = tick && moduleMode[i].comparatorEnable &&
                           hitsValue(cntNext, cmpHigh_q[i], cmpLow_q[i]); // R12
      assign pwmOn[i] = moduleMode[i].pwmEnable && moduleMode[i].comparatorEnable; // R17
      assign hsoOn[i] = moduleMode[i].outputFlipEnable && moduleMode[i].comparatorEnable &&
                        moduleMode[i].compareHitFlagEnable && !pwmOn[i]; // R14
      assign eventSet[i] = captureHit[i] | (matchHit[i] & moduleMode[i].compareHitFlagEnable); // R07 R11 R13
      assign irqEnVec[i] = moduleMode[i].moduleIrqEnable;

      // compare bytes: capture beats pwm reload, which beats a software low-byte write
      always_ff @(posedge mclk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
          cmpLow_q[i] <= pgca_pkg::CMP_RESET;
          cmpHigh_q[i] <= pgca_pkg::CMP_RESET;
        end else if (captureHit[i]) begin
          cmpLow_q[i] <= cnt_q[7:0]; // R11
          cmpHigh_q[i] <= cnt_q[15:8]; // R11
        end else begin
          if (pwmOn[i] && tick && cnt_q[7:0] == pgca_pkg::LOW_MAX) begin
            cmpLow_q[i] <= cmpHigh_q[i]; // R16
          end else if (cmpWrite[i].wrLow) begin
            cmpLow_q[i] <= cmpWrite[i].data;
          end
          if (cmpWrite[i].wrHigh) begin
            cmpHigh_q[i] <= cmpWrite[i].data;
          end
        end
      end

      // event flag: hardware set wins over software clear
      always_ff @(posedge mclk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
          eventFlag_q[i] <= 1'b0;
        end else if (eventSet[i]) begin
          eventFlag_q[i] <= 1'b1; // R07
        end else if (eventFlagClr[i]) begin
          eventFlag_q[i] <= 1'b0; // R07
        end
      end

      // pin driver; a toggle starts from the level the port latch last drove
      always_ff @(posedge mclk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
          ioOut_q[i] <= 1'b0;
          ioOe_q[i] <= 1'b0;
        end else if (pwmOn[i]) begin
          ioOut_q[i] <= (cnt_q[7:0] >= cmpLow_q[i]); // R15
          ioOe_q[i] <= 1'b1;
        end else if (hsoOn[i]) begin
          ioOut_q[i] <= matchHit[i] ? ~ioOut_q[i] : ioOut_q[i]; // R14
          ioOe_q[i] <= 1'b1;
        end else begin
          ioOut_q[i] <= gpioOut[i]; // R21
          ioOe_q[i] <= gpioOe[i]; // R21
        end
      end

      // per-module checks; each one tracks the flop it guards
      a_capture_load: assert property (captureHit[i] |=> // R11
          {cmpHigh_q[i], cmpLow_q[i]} == $past(cnt_q) && eventFlag_q[i])
        else $error("capture did not load counter and flag");
      a_pwm_level: assert property (pwmOn[i] |=> // R15
          ioOut_q[i] == ($past(cnt_q[7:0]) >= $past(cmpLow_q[i])) && ioOe_q[i])
        else $error("pwm pin level wrong");
      a_timer_flag: assert property (matchHit[i] && moduleMode[i].compareHitFlagEnable |=> // R13
          eventFlag_q[i] ##1 (eventFlag_q[i] || $past(eventFlagClr[i])))
        else $error("timer match did not set event flag");
      a_hso_flip: assert property (hsoOn[i] && matchHit[i] |=> // R14
          ioOut_q[i] != $past(ioOut_q[i]))
        else $error("output pin did not flip on match");

      // a reload only counts when no capture took the bytes in that cycle
      a_pwm_reload: assert property ( // R16
          pwmOn[i] && tick && cnt_q[7:0] == pgca_pkg::LOW_MAX && !captureHit[i] |=>
          cmpLow_q[i] == $past(cmpHigh_q[i]))
        else $error("pwm compare low not reloaded at wrap");
      a_event_sticky: assert property (eventFlag_q[i] && !eventFlagClr[i] |=> // R07
          eventFlag_q[i])
        else $error("event flag dropped without software clear");
      // a pin the array does not claim follows the port latch one cycle later
      a_gpio_pass: assert property (!pwmOn[i] && !hsoOn[i] |=> // R21
          ioOut_q[i] == $past(gpioOut[i]) && ioOe_q[i] == $past(gpioOe[i]))
        else $error("unclaimed pin did not follow port latch");
    end
  endgenerate

  // watchdog on module 4 only, judged like any other match
  // the comparator enable is not needed, so a stray mode write cannot silence it
  assign wdogHit = counterCfg.watchdogEnable && tick && // R18
      hitsValue(cntNext, cmpHigh_q[pgca_pkg::WDOG_MODULE], cmpLow_q[pgca_pkg::WDOG_MODULE]);

  // internal reset pulse; the block never touches the reset pin itself
  always_ff @(posedge mclk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      wdogReset_q <= 1'b0;
    end else begin
      wdogReset_q <= wdogHit; // R19
    end
  end

  // one shared request from every enabled source
  // lags its flags by a cycle so the output stays a plain flop
  always_ff @(posedge mclk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ovfFlag_q & counterCfg.overflowIrqEnable) | |(eventFlag_q & irqEnVec); // R06 R08 R09
    end
  end

  // outputs straight from flops
  assign countValue = cnt_q;
  assign counterOverflowFlag = ovfFlag_q;
  assign moduleEventFlag = eventFlag_q;
  assign irqRequest = irq_q;
  assign watchdogReset = wdogReset_q;
  assign moduleIoPinOut = ioOut_q;
  assign moduleIoPinOe = ioOe_q;
  always_comb begin
    for (int k = 0; k < NM; k++) begin
      moduleCompareLow[k] = cmpLow_q[k];
      moduleCompareHigh[k] = cmpHigh_q[k];
    end
  end

  // a count step under the clk/6 source, then five quiet cycles
  sequence s_div6_step;
    $changed(cnt_q) && counterCfg.countSource == pgca_pkg::SRC_DIV6;
  endsequence
  sequence s_div6_quiet;
    ($stable(cnt_q) || counterCfg.countSource != pgca_pkg::SRC_DIV6) [*5];
  endsequence

  a_div6_spacing: assert property (s_div6_step |=> s_div6_quiet) // R02
    else $error("clk/6 source stepped too often");
  // run and idle gating both freeze the counter
  a_run_hold: assert property (!counterCfg.counterRun |=> $stable(cnt_q)) // R05
    else $error("counter moved while stopped");
  a_idle_hold: assert property (counterCfg.haltInIdle && idleMode |=> $stable(cnt_q)) // R04
    else $error("counter moved during idle halt");
  a_cnt_wrap: assert property (overflowHit |=> cnt_q == pgca_pkg::CNT_RESET && ovfFlag_q) // R22
    else $error("wrap did not clear counter and set overflow");
  a_ovf_sticky: assert property (ovfFlag_q && !overflowFlagClr |=> ovfFlag_q) // R06
    else $error("overflow flag dropped without software clear");
  a_ovf_irq: assert property (ovfFlag_q && counterCfg.overflowIrqEnable |=> irqRequest) // R08
    else $error("overflow did not raise request");
  a_irq_gate: assert property (irqRequest |-> // R09
      $past(ovfFlag_q & counterCfg.overflowIrqEnable) || $past(|(eventFlag_q & irqEnVec)))
    else $error("request raised with no enabled source");
  a_wdog_reset: assert property (wdogHit |=> // R19
      watchdogReset ##1 (!watchdogReset || $past(wdogHit)))
    else $error("watchdog match did not pulse reset");
  a_wdog_gate: assert property (!counterCfg.watchdogEnable |=> !watchdogReset) // R18
    else $error("watchdog reset without watchdog enable");
  // one step per count pulse, so no pulse is lost or doubled
  a_cnt_step: assert property (tick |=> cnt_q == 16'($past(cnt_q) + pgca_pkg::CNT_ONE)) // R22
    else $error("counter did not step by one");

endmodule // pgca_top

// *** pgca_pin_model.sv ***
// far-side model of the counter array pins: capture inputs and the external count pin
// assumes the bench sets drive levels at the falling clock edge and calls extPulses
module pgca_pin_model (
  input wire logic mclk, // bench clock, paces the count pulses
  input wire logic [4:0] pinOut, // array pin drive level
  input wire logic [4:0] pinOe, // array pin drive enable
  output logic [4:0] pinIn, // resolved pin level
  output logic extCount // external count pin
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] drive = 5'h00;

  // a pin the array drives shows its level, otherwise the outside level
  assign pinIn = (pinOe & pinOut) | (~pinOe & drive);

  // count pin stands low outside bursts
  initial extCount = 1'b0;

  // one pulse per eight clocks, well inside the quarter-rate ceiling of the sync path
  task automatic extPulses(input int n);
    repeat (n) begin
      repeat (4) @(negedge mclk);
      extCount = 1'b1;
      repeat (4) @(negedge mclk);
      extCount = 1'b0;
    end
  endtask
endmodule // pgca_pin_model

// *** pgca_tb_top.sv ***
// self-checking bench for the programmable counter array top
// assumes inputs change at the falling edge and one clock domain at 200 MHz
module pgca_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic idleMode = 1'b0;
  logic tmr0Overflow = 1'b0;
  pgca_pkg::pgca_counter_cfg_type cfg = '0;
  pgca_pkg::pgca_module_mode_type mode [pgca_pkg::NUM_MODULES];
  pgca_pkg::pgca_compare_write_type cw [pgca_pkg::NUM_MODULES];
  logic ofClr = 1'b0;
  logic [4:0] efClr = 5'h00;
  logic [4:0] gpioOut = 5'h00;
  logic [4:0] gpioOe = 5'h00;
  logic [15:0] countValue;
  logic [7:0] cmpLo [pgca_pkg::NUM_MODULES];
  logic [7:0] cmpHi [pgca_pkg::NUM_MODULES];
  logic ovf;
  logic [4:0] evf;
  logic irq;
  logic wdRst;
  logic [4:0] pinOut;
  logic [4:0] pinOe;
  logic [4:0] pinIn;
  logic extCnt;
  logic [15:0] c;
  logic [7:0] d;
  logic [6:0] capMode [3] = '{7'h20, 7'h10, 7'h30};
  int n_fail = 0;
  int tests_run = 0;
  int wdCnt = 0;
  int w0;

  always #2.5 mclk = ~mclk;

  // count watchdog pulses, a one-cycle pulse is easy to miss by polling;
  // sampled mid-cycle so the pulse is settled when it is looked at
  always @(negedge mclk) if (wdRst === 1'b1) wdCnt++;

  pgca_top i_dut (.mclk(mclk), .rstn(rstn), .idleMode(idleMode), .tmr0Overflow(tmr0Overflow),
    .extCountInput(extCnt), .counterCfg(cfg), .moduleMode(mode), .cmpWrite(cw),
    .overflowFlagClr(ofClr), .eventFlagClr(efClr), .moduleIoPinIn(pinIn), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .countValue(countValue), .moduleCompareLow(cmpLo),
    .moduleCompareHigh(cmpHi), .counterOverflowFlag(ovf), .moduleEventFlag(evf),
    .irqRequest(irq), .watchdogReset(wdRst), .moduleIoPinOut(pinOut), .moduleIoPinOe(pinOe));

  pgca_pin_model i_pins (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn),
    .extCount(extCnt));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic endTest(input string name);
    $display("test %s finished, failures so far %0d", name, n_fail);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one timer 0 pulse per count step, so the counter moves by exactly n
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge mclk) tmr0Overflow = 1'b1;
      @(negedge mclk) tmr0Overflow = 1'b0;
    end
  endtask

  task automatic wrCmp(input int m, input logic [15:0] v);
    @(negedge mclk) cw[m] = '{1'b1, 1'b0, v[7:0]};
    @(negedge mclk) cw[m] = '{1'b0, 1'b1, v[15:8]};
    @(negedge mclk) cw[m] = '0;
  endtask

  // the prescaler runs free, so a whole number of periods gives an exact count
  task automatic srcChk(input logic [1:0] s, input int cyc, input logic [15:0] dlt);
    logic [15:0] c0;
    @(negedge mclk) cfg.countSource = s;
    c0 = countValue;
    repeat (cyc) @(negedge mclk);
    chk(countValue - c0, dlt, "count step");
  endtask

  initial begin
    foreach (mode[i]) begin
      mode[i] = '0;
      cw[i] = '0;
    end
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    chk(countValue, 16'h0000, "reset count");
    chk({4'h0, ovf, evf, irq, pinOe}, 16'h0000, "reset flags");
    endTest("reset");
    cfg.counterRun = 1'b1;
    srcChk(pgca_pkg::SRC_DIV6, 60, 16'h000A);
    srcChk(pgca_pkg::SRC_DIV2, 20, 16'h000A);
    cfg.countSource = pgca_pkg::SRC_TMR0;
    c = countValue;
    tick(7);
    chk(countValue - c, 16'h0007, "timer0 source");
    cfg.countSource = pgca_pkg::SRC_EXT;
    c = countValue;
    i_pins.extPulses(4);
    repeat (6) @(negedge mclk);
    chk(countValue - c, 16'h0004, "pin source");
    cfg.haltInIdle = 1'b1;
    idleMode = 1'b1;
    srcChk(pgca_pkg::SRC_DIV2, 20, 16'h0000);
    cfg.haltInIdle = 1'b0;
    srcChk(pgca_pkg::SRC_DIV2, 20, 16'h000A);
    idleMode = 1'b0;
    cfg.counterRun = 1'b0;
    srcChk(pgca_pkg::SRC_DIV2, 20, 16'h0000);
    cfg.counterRun = 1'b1;
    endTest("sources");
    // full lap of the counter with a pulse every clock
    cfg.countSource = pgca_pkg::SRC_TMR0;
    cfg.overflowIrqEnable = 1'b1;
    c = countValue;
    @(negedge mclk) tmr0Overflow = 1'b1;
    repeat (65536) @(negedge mclk);
    tmr0Overflow = 1'b0;
    chk(countValue, c, "full lap");
    repeat (2) @(negedge mclk);
    chk(16'(ovf), 16'h0001, "overflow flag");
    chk(16'(irq), 16'h0001, "overflow irq");
    @(negedge mclk) ofClr = 1'b1;
    @(negedge mclk) ofClr = 1'b0;
    @(negedge mclk);
    chk({14'h0000, ovf, irq}, 16'h0000, "overflow clear");
    cfg.overflowIrqEnable = 1'b0;
    endTest("overflow");
    wrCmp(1, countValue + 16'h0002);
    mode[1] = 7'h08;
    tick(2);
    chk(16'(evf[1]), 16'h0000, "no comparator");
    wrCmp(1, countValue + 16'h0005);
    mode[1] = 7'h48;
    tick(4);
    chk(16'(evf[1]), 16'h0000, "before match");
    tick(1);
    chk(16'(evf[1]), 16'h0001, "at match");
    repeat (2) @(negedge mclk);
    chk(16'(irq), 16'h0000, "irq masked");
    mode[1] = 7'h49;
    repeat (2) @(negedge mclk);
    chk(16'(irq), 16'h0001, "irq enabled");
    @(negedge mclk) efClr = 5'h02;
    @(negedge mclk) efClr = 5'h00;
    @(negedge mclk);
    chk({14'h0000, evf[1], irq}, 16'h0000, "event clear");
    mode[1] = '0;
    endTest("timer");
    gpioOe = 5'h15;
    gpioOut = 5'h0A;
    repeat (2) @(negedge mclk);
    chk({6'h00, pinOe, pinOut}, {6'h00, 5'h15, 5'h0A}, "port pins");
    gpioOe = 5'h00;
    gpioOut = 5'h00;
    repeat (2) @(negedge mclk);
    mode[2] = 7'h4C;
    wrCmp(2, countValue + 16'h0003);
    tick(2);
    chk({14'h0000, pinOe[2], pinOut[2]}, 16'h0002, "hso before");
    tick(1);
    @(negedge mclk);
    chk({14'h0000, pinOe[2], pinOut[2]}, 16'h0003, "hso toggle");
    wrCmp(2, countValue + 16'h0002);
    tick(2);
    @(negedge mclk);
    chk({14'h0000, pinOe[2], pinOut[2]}, 16'h0002, "hso toggle back");
    mode[2] = '0;
    endTest("hso");
    d = 8'h7F - countValue[7:0];
    tick(int'(d));
    wrCmp(3, 16'h4080);
    mode[3] = 7'h02;
    repeat (2) @(negedge mclk);
    chk(16'(pinOe[3]), 16'h0000, "pwm needs comparator");
    mode[3] = 7'h42;
    repeat (2) @(negedge mclk);
    chk({14'h0000, pinOe[3], pinOut[3]}, 16'h0002, "pwm below");
    tick(1);
    repeat (2) @(negedge mclk);
    chk({14'h0000, pinOe[3], pinOut[3]}, 16'h0003, "pwm equal");
    tick(127);
    chk(16'(cmpLo[3]), 16'h0080, "no early reload");
    tick(1);
    @(negedge mclk);
    chk(16'(cmpLo[3]), 16'h0040, "reload at wrap");
    chk({14'h0000, pinOe[3], pinOut[3]}, 16'h0002, "pwm after wrap");
    tick(64);
    repeat (2) @(negedge mclk);
    chk({14'h0000, pinOe[3], pinOut[3]}, 16'h0003, "pwm new duty");
    mode[3] = '0;
    endTest("pwm");
    // e is 0 for a rising edge and 1 for a falling edge
    for (int m = 0; m < 3; m++) begin
      for (int e = 0; e < 2; e++) begin
        mode[0] = '0;
        i_pins.drive[0] = e[0];
        repeat (6) @(negedge mclk);
        efClr = 5'h01;
        @(negedge mclk) efClr = 5'h00;
        mode[0] = capMode[m];
        tick(1);
        c = countValue;
        i_pins.drive[0] = ~e[0];
        repeat (8) @(negedge mclk);
        chk(16'(evf[0]), 16'(e ? capMode[m][4] : capMode[m][5]), "capture flag");
        if (e ? capMode[m][4] : capMode[m][5])
          chk({cmpHi[0], cmpLo[0]}, c, "captured value");
      end
    end
    mode[0] = '0;
    endTest("capture");
    cfg.watchdogEnable = 1'b1;
    w0 = wdCnt;
    wrCmp(4, countValue + 16'h0003);
    tick(2);
    wrCmp(4, countValue + 16'h0004);
    tick(2);
    chk(16'(wdCnt - w0), 16'h0000, "refreshed watchdog");
    tick(2);
    repeat (2) @(negedge mclk);
    chk(16'(wdCnt - w0), 16'h0001, "watchdog reset");
    cfg.watchdogEnable = 1'b0;
    w0 = wdCnt;
    wrCmp(4, countValue + 16'h0002);
    tick(2);
    repeat (2) @(negedge mclk);
    chk(16'(wdCnt - w0), 16'h0000, "watchdog off");
    endTest("watchdog");
    wrap_up();
  end

  // the full lap needs 65536 clocks; allow some margin
  initial begin
    #450000;
    n_fail++;
    $display("wrong value at %0t: run did not finish in time", $time);
    wrap_up();
  end
endmodule // pgca_tb_top
